//--- hw/frame_link_if.sv
// signals between the spi link domain and the control domain
`timescale 1ns/1ps
interface frame_link_if;
  logic [16:0] rx_word;
  logic [5:0]  bit_cnt;
  logic [15:0] hold_word;
  logic        chain_mode;
  modport ctrl (input rx_word, bit_cnt, output hold_word, chain_mode);
  modport link (output rx_word, bit_cnt, input hold_word, chain_mode);
endinterface

//--- hw/io_route_pkg.sv
// shared constants and types for the i/o routing and spi mode block
package io_route_pkg;
  localparam int          WORD_W     = 16;
  localparam int          FRAME_W    = 17;
  localparam int          CNT_W      = 6;
  localparam int          PIN_N      = 6;
  localparam logic [5:0]  CNT_ZERO   = 6'h00;
  localparam logic [5:0]  CNT_ONE    = 6'h01;
  localparam logic [5:0]  CNT_MAX    = 6'h3F;
  localparam logic [5:0]  LEN_CMD    = 6'h10;
  localparam logic [5:0]  LEN_PAR    = 6'h11;
  localparam logic [5:0]  LEN_WORD   = 6'h10;
  // command opcode field
  localparam int          OP_MSB     = 15;
  localparam int          OP_LSB     = 13;
  localparam logic [2:0]  OP_READ    = 3'h0;
  localparam logic [2:0]  OP_MODE    = 3'h1;
  localparam logic [2:0]  OP_UNLOCK  = 3'h2;
  localparam logic [2:0]  OP_CLEAR   = 3'h3;
  localparam int          MODE_RWM   = 0;
  localparam int          MODE_CHAIN = 1;
  localparam int          UNLOCK_BIT = 0;
  // output routing codes
  localparam logic [2:0]  ROUTE_UVW_ABZ  = 3'h0;
  localparam logic [2:0]  ROUTE_UVW_SSI  = 3'h1;
  localparam logic [2:0]  ROUTE_SSI_ABZ  = 3'h2;
  localparam logic [2:0]  ROUTE_UVW_INV  = 3'h3;
  localparam logic [2:0]  ROUTE_ABZ_INV  = 3'h4;
  localparam logic [2:0]  ROUTE_UVW_ONLY = 3'h5;
  localparam logic [2:0]  ROUTE_ABZ_ONLY = 3'h6;
  localparam logic [2:0]  ROUTE_SSI_ONLY = 3'h7;
  // pin slots in routing order io6, io1, io5, io2, io4, io3
  localparam int          PIN_IO6 = 0;
  localparam int          PIN_IO1 = 1;
  localparam int          PIN_IO5 = 2;
  localparam int          PIN_IO2 = 3;
  localparam int          PIN_IO4 = 4;
  localparam int          PIN_IO3 = 5;
  localparam int          FIRST_GROUP_N = 3;
  typedef enum logic [3:0] {
    SIG_NONE, SIG_U, SIG_V, SIG_W, SIG_A, SIG_B, SIG_Z,
    SIG_NU, SIG_NV, SIG_NW, SIG_NA, SIG_NB, SIG_NZ,
    SIG_SCK, SIG_SDA, SIG_PWM
  } sig_type;
  typedef enum {REPLY_ANGLE, REPLY_ECHO} reply_type;
endpackage

//--- hw/io_route_top.sv
// i/o routing matrix, pin drive, parity check, flags and spi mode lock
`timescale 1ns/1ps
module io_route_top #(
  parameter logic PARITY_ODD = 1'b0
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // spi pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        copi,
  output logic             cipo_out,
  output logic             cipo_oe_n,
  output logic             cipo_pulldown_en,
  output logic             cs_pullup_en,
  output logic             sclk_pulldown_en,
  output logic             copi_pulldown_en,
  output logic             cs_pin_out,
  output logic             cs_pin_oe_n,
  output logic             sclk_pin_out,
  output logic             sclk_pin_oe_n,
  output logic             copi_pin_out,
  output logic             copi_pin_oe_n,
  // configuration
  input  wire logic        parity_check_enable,
  input  wire logic [2:0]  output_route_select,
  input  wire logic        drive_type_first_group,
  input  wire logic        drive_type_second_group,
  input  wire logic        spi_input_bias_enable,
  input  wire logic        idle_output_float,
  // signal sources
  input  wire logic [15:0] angle,
  input  wire logic        u_sig,
  input  wire logic        v_sig,
  input  wire logic        w_sig,
  input  wire logic        a_sig,
  input  wire logic        b_sig,
  input  wire logic        z_sig,
  input  wire logic        sync_serial_clock_out,
  input  wire logic        sync_serial_data_out,
  input  wire logic        pwm_sig,
  // memory restore
  input  wire logic        restore_valid,
  input  wire logic [1:0]  restore_mode,
  input  wire logic [7:0]  restore_crc_stored,
  input  wire logic [7:0]  restore_crc_computed,
  input  wire logic        memory_busy_event,
  // general output pins, slot order io6 io1 io5 io2 io4 io3
  output logic [5:0]       gen_pin_out,
  output logic [5:0]       gen_pin_oe_n,
  // mode and status
  output logic             mode_register_unlock,
  output logic             reduced_pin_mode,
  output logic             chain_mode,
  output logic             parity_error_flag,
  output logic             restore_crc_error_flag,
  output logic             memory_busy_error_flag,
  // other accepted commands
  output logic             cmd_valid,
  output logic [15:0]      cmd_word
);
  frame_link_if lk ();

  spi_frame_link u_link (
    .sclk (sclk),
    .cs_n (cs_n),
    .copi (copi),
    .rstn (rstn),
    .cipo (cipo_out),
    .lk   (lk)
  );

  // chip select synchroniser and frame end
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic frame_end;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
    end else begin
      cs_s1_ff <= cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
    end
  end
  // link words are frozen once chip select is high again
  assign frame_end = cs_s2_ff & ~cs_s3_ff;

  // control state
  logic                   perr_ff, crc_ff, busy_ff;
  logic                   nxt_perr, nxt_crc, nxt_busy;
  logic                   unlock_ff, nxt_unlock;
  logic                   pend_rwm_ff, pend_chain_ff;
  logic                   nxt_pend_rwm, nxt_pend_chain;
  logic                   rwm_ff, chain_ff, nxt_rwm, nxt_chain;
  io_route_pkg::reply_type reply_ff, nxt_reply;
  logic [15:0]            echo_ff, nxt_echo, hold_ff, nxt_hold;
  logic                   cmd_valid_ff, nxt_cmd_valid;
  logic [15:0]            cmd_word_ff, nxt_cmd_word;
  logic                   accept, perr_hit, par_ok, clear_hit;
  logic [15:0]            cmd;
  logic [2:0]             op;

  always_comb begin
    par_ok   = (^lk.rx_word) == PARITY_ODD;
    accept   = 1'b0;
    perr_hit = 1'b0;
    cmd      = lk.rx_word[15:0];
    if (frame_end && !chain_ff) begin
      if (parity_check_enable) begin
        if (lk.bit_cnt == io_route_pkg::LEN_PAR) begin
          cmd = lk.rx_word[16:1];
          if (par_ok) begin
            accept = 1'b1;
          end else begin
            perr_hit = 1'b1;
          end
        end
        // a bare command word falls through, no flag
      end else if (lk.bit_cnt == io_route_pkg::LEN_CMD) begin
        accept = 1'b1;
      end
    end
    op        = cmd[io_route_pkg::OP_MSB:io_route_pkg::OP_LSB];
    clear_hit = accept && op == io_route_pkg::OP_CLEAR;
    // set wins over clear
    nxt_perr  = perr_hit | (perr_ff & ~clear_hit);
    nxt_crc   = (restore_valid &&
                 restore_crc_stored != restore_crc_computed) |
                (crc_ff & ~clear_hit);
    nxt_busy  = memory_busy_event | (busy_ff & ~clear_hit);
    nxt_unlock = unlock_ff;
    if (accept && op == io_route_pkg::OP_UNLOCK) begin
      nxt_unlock = cmd[io_route_pkg::UNLOCK_BIT];
    end
    nxt_pend_rwm   = pend_rwm_ff;
    nxt_pend_chain = pend_chain_ff;
    if (accept && op == io_route_pkg::OP_MODE && unlock_ff) begin
      nxt_pend_rwm   = cmd[io_route_pkg::MODE_RWM];
      nxt_pend_chain = cmd[io_route_pkg::MODE_CHAIN];
    end else if (restore_valid &&
                 restore_crc_stored == restore_crc_computed) begin
      nxt_pend_rwm   = restore_mode[io_route_pkg::MODE_RWM];
      nxt_pend_chain = restore_mode[io_route_pkg::MODE_CHAIN];
    end
    // applied only while locked
    nxt_rwm   = unlock_ff ? rwm_ff : pend_rwm_ff;
    nxt_chain = unlock_ff ? chain_ff : pend_chain_ff;
    nxt_reply = reply_ff;
    nxt_echo  = echo_ff;
    if (accept && op != io_route_pkg::OP_READ) begin
      nxt_reply = io_route_pkg::REPLY_ECHO;
      nxt_echo  = cmd;
    end else if (frame_end) begin
      nxt_reply = io_route_pkg::REPLY_ANGLE;
    end
    nxt_hold = hold_ff;
    if (cs_s2_ff) begin
      unique case (reply_ff)
        io_route_pkg::REPLY_ANGLE: nxt_hold = angle;
        io_route_pkg::REPLY_ECHO:  nxt_hold = echo_ff;
      endcase
      // chain readout always leads with own angle
      if (chain_ff) begin
        nxt_hold = angle;
      end
    end
    nxt_cmd_valid = accept && op != io_route_pkg::OP_READ &&
                    op != io_route_pkg::OP_MODE &&
                    op != io_route_pkg::OP_UNLOCK &&
                    op != io_route_pkg::OP_CLEAR;
    nxt_cmd_word  = nxt_cmd_valid ? cmd : cmd_word_ff;
  end

  // power-up leaves normal spi mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      perr_ff       <= 1'b0;
      crc_ff        <= 1'b0;
      busy_ff       <= 1'b0;
      unlock_ff     <= 1'b0;
      pend_rwm_ff   <= 1'b0;
      pend_chain_ff <= 1'b0;
      rwm_ff        <= 1'b0;
      chain_ff      <= 1'b0;
      reply_ff      <= io_route_pkg::REPLY_ANGLE;
      echo_ff       <= 16'h0000;
      hold_ff       <= 16'h0000;
      cmd_valid_ff  <= 1'b0;
      cmd_word_ff   <= 16'h0000;
    end else begin
      perr_ff       <= nxt_perr;
      crc_ff        <= nxt_crc;
      busy_ff       <= nxt_busy;
      unlock_ff     <= nxt_unlock;
      pend_rwm_ff   <= nxt_pend_rwm;
      pend_chain_ff <= nxt_pend_chain;
      rwm_ff        <= nxt_rwm;
      chain_ff      <= nxt_chain;
      reply_ff      <= nxt_reply;
      echo_ff       <= nxt_echo;
      hold_ff       <= nxt_hold;
      cmd_valid_ff  <= nxt_cmd_valid;
      cmd_word_ff   <= nxt_cmd_word;
    end
  end

  assign lk.hold_word           = hold_ff;
  assign lk.chain_mode          = chain_ff;
  assign parity_error_flag      = perr_ff;
  assign restore_crc_error_flag = crc_ff;
  assign memory_busy_error_flag = busy_ff;
  assign mode_register_unlock   = unlock_ff;
  assign reduced_pin_mode       = rwm_ff;
  assign chain_mode             = chain_ff;
  assign cmd_valid              = cmd_valid_ff;
  assign cmd_word               = cmd_word_ff;

  // routing matrix
  io_route_pkg::sig_type route [io_route_pkg::PIN_N];
  always_comb begin
    unique case (output_route_select)
      io_route_pkg::ROUTE_UVW_ABZ: route = '{io_route_pkg::SIG_U,
        io_route_pkg::SIG_V, io_route_pkg::SIG_W, io_route_pkg::SIG_A,
        io_route_pkg::SIG_B, io_route_pkg::SIG_Z};
      io_route_pkg::ROUTE_UVW_SSI: route = '{io_route_pkg::SIG_U,
        io_route_pkg::SIG_V, io_route_pkg::SIG_W, io_route_pkg::SIG_SDA,
        io_route_pkg::SIG_SCK, io_route_pkg::SIG_PWM};
      io_route_pkg::ROUTE_SSI_ABZ: route = '{io_route_pkg::SIG_SCK,
        io_route_pkg::SIG_SDA, io_route_pkg::SIG_PWM, io_route_pkg::SIG_A,
        io_route_pkg::SIG_B, io_route_pkg::SIG_Z};
      io_route_pkg::ROUTE_UVW_INV: route = '{io_route_pkg::SIG_U,
        io_route_pkg::SIG_V, io_route_pkg::SIG_W, io_route_pkg::SIG_NV,
        io_route_pkg::SIG_NU, io_route_pkg::SIG_NW};
      io_route_pkg::ROUTE_ABZ_INV: route = '{io_route_pkg::SIG_NB,
        io_route_pkg::SIG_NA, io_route_pkg::SIG_NZ, io_route_pkg::SIG_A,
        io_route_pkg::SIG_B, io_route_pkg::SIG_Z};
      io_route_pkg::ROUTE_UVW_ONLY: route = '{io_route_pkg::SIG_U,
        io_route_pkg::SIG_V, io_route_pkg::SIG_W, io_route_pkg::SIG_NONE,
        io_route_pkg::SIG_NONE, io_route_pkg::SIG_NONE};
      io_route_pkg::ROUTE_ABZ_ONLY: route = '{io_route_pkg::SIG_NONE,
        io_route_pkg::SIG_NONE, io_route_pkg::SIG_NONE, io_route_pkg::SIG_A,
        io_route_pkg::SIG_B, io_route_pkg::SIG_Z};
      io_route_pkg::ROUTE_SSI_ONLY: route = '{io_route_pkg::SIG_SCK,
        io_route_pkg::SIG_SDA, io_route_pkg::SIG_PWM,
        io_route_pkg::SIG_NONE, io_route_pkg::SIG_NONE,
        io_route_pkg::SIG_NONE};
    endcase
  end

  logic [15:0] src;
  always_comb begin
    src = 16'h0000;
    src[io_route_pkg::SIG_U]   = u_sig;
    src[io_route_pkg::SIG_V]   = v_sig;
    src[io_route_pkg::SIG_W]   = w_sig;
    src[io_route_pkg::SIG_A]   = a_sig;
    src[io_route_pkg::SIG_B]   = b_sig;
    src[io_route_pkg::SIG_Z]   = z_sig;
    src[io_route_pkg::SIG_NU]  = ~u_sig;
    src[io_route_pkg::SIG_NV]  = ~v_sig;
    src[io_route_pkg::SIG_NW]  = ~w_sig;
    src[io_route_pkg::SIG_NA]  = ~a_sig;
    src[io_route_pkg::SIG_NB]  = ~b_sig;
    src[io_route_pkg::SIG_NZ]  = ~z_sig;
    src[io_route_pkg::SIG_SCK] = sync_serial_clock_out;
    src[io_route_pkg::SIG_SDA] = sync_serial_data_out;
    src[io_route_pkg::SIG_PWM] = pwm_sig;
  end

  // per pin value and drive
  logic [5:0] nxt_gen_out, nxt_gen_oe_n;
  genvar gi;
  generate
    for (gi = 0; gi < io_route_pkg::PIN_N; gi++) begin : g_pin
      logic od_sel;
      assign od_sel = (gi < io_route_pkg::FIRST_GROUP_N) ?
                      drive_type_first_group :
                      drive_type_second_group;
      assign nxt_gen_out[gi]  = src[route[gi]];
      // open drain only sinks; serial clock keeps push-pull
      assign nxt_gen_oe_n[gi] = !(route[gi] != io_route_pkg::SIG_NONE &&
        (!od_sel || route[gi] == io_route_pkg::SIG_SCK ||
         !src[route[gi]]));
    end
  endgenerate

  logic [5:0] gen_out_ff, gen_oe_n_ff;
  logic       cs_out_ff, sclk_out_ff, copi_out_ff;
  logic       cs_oe_n_ff, sclk_oe_n_ff, copi_oe_n_ff;
  logic       bias_up_ff, bias_dn_ff;
  logic       nxt_bias_up, nxt_bias_dn;
  always_comb begin
    nxt_bias_up = spi_input_bias_enable & ~rwm_ff;
    nxt_bias_dn = spi_input_bias_enable & ~rwm_ff;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_out_ff   <= 6'h00;
      gen_oe_n_ff  <= 6'h3F;
      cs_out_ff    <= 1'b0;
      sclk_out_ff  <= 1'b0;
      copi_out_ff  <= 1'b0;
      cs_oe_n_ff   <= 1'b1;
      sclk_oe_n_ff <= 1'b1;
      copi_oe_n_ff <= 1'b1;
      bias_up_ff   <= 1'b1;
      bias_dn_ff   <= 1'b1;
    end else begin
      gen_out_ff   <= nxt_gen_out;
      gen_oe_n_ff  <= nxt_gen_oe_n;
      // spi input pins carry io3 io4 io2 routing
      copi_out_ff  <= nxt_gen_out[io_route_pkg::PIN_IO3];
      cs_out_ff    <= nxt_gen_out[io_route_pkg::PIN_IO4];
      sclk_out_ff  <= nxt_gen_out[io_route_pkg::PIN_IO2];
      copi_oe_n_ff <= ~rwm_ff | nxt_gen_oe_n[io_route_pkg::PIN_IO3];
      cs_oe_n_ff   <= ~rwm_ff | nxt_gen_oe_n[io_route_pkg::PIN_IO4];
      sclk_oe_n_ff <= ~rwm_ff | nxt_gen_oe_n[io_route_pkg::PIN_IO2];
      bias_up_ff   <= nxt_bias_up;
      bias_dn_ff   <= nxt_bias_dn;
    end
  end

  assign gen_pin_out      = gen_out_ff;
  assign gen_pin_oe_n     = gen_oe_n_ff;
  assign copi_pin_out     = copi_out_ff;
  assign cs_pin_out       = cs_out_ff;
  assign sclk_pin_out     = sclk_out_ff;
  assign copi_pin_oe_n    = copi_oe_n_ff;
  assign cs_pin_oe_n      = cs_oe_n_ff;
  assign sclk_pin_oe_n    = sclk_oe_n_ff;
  assign cs_pullup_en     = bias_up_ff;
  assign sclk_pulldown_en = bias_dn_ff;
  assign copi_pulldown_en = bias_dn_ff;
  // driven while selected, idle pull or float
  assign cipo_oe_n        = cs_n;
  assign cipo_pulldown_en = cs_n & ~idle_output_float;

  a_parity_sets: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end && parity_check_enable && !chain_ff &&
    lk.bit_cnt == 6'h11 && !par_ok |=> parity_error_flag && !cmd_valid)
    else $error("parity error not flagged");
  a_short_silent: assert property (
    @(posedge clk) disable iff (!rstn)
    frame_end && parity_check_enable && lk.bit_cnt == 6'h10 &&
    !parity_error_flag |=> !parity_error_flag && !cmd_valid)
    else $error("short frame flagged or accepted");
  a_angle_after: assert property (
    @(posedge clk) disable iff (!rstn)
    perr_hit |=> reply_ff == io_route_pkg::REPLY_ANGLE ##1
    hold_ff == $past(angle))
    else $error("no angle after parity error");
  a_crc_flag: assert property (
    @(posedge clk) disable iff (!rstn)
    restore_valid && restore_crc_stored != restore_crc_computed
    |=> restore_crc_error_flag)
    else $error("crc mismatch not flagged");
  a_flag_sticky: assert property (
    @(posedge clk) disable iff (!rstn)
    parity_error_flag && !clear_hit |=> parity_error_flag)
    else $error("error flag dropped without clear");
  a_lock_holds: assert property (
    @(posedge clk) disable iff (!rstn)
    !unlock_ff && !restore_valid |=> $stable(pend_rwm_ff) &&
    $stable(pend_chain_ff))
    else $error("mode written while locked");
  a_mode_waits: assert property (
    @(posedge clk) disable iff (!rstn)
    unlock_ff |=> $stable(reduced_pin_mode) && $stable(chain_mode))
    else $error("mode applied while unlocked");
  a_chain_readonly: assert property (
    @(posedge clk) disable iff (!rstn)
    chain_ff |=> !cmd_valid && $stable(mode_register_unlock))
    else $error("command accepted in chain mode");
  a_sck_pushpull: assert property (
    @(posedge clk) disable iff (!rstn)
    output_route_select == 3'h2 |=> !gen_pin_oe_n[0])
    else $error("serial clock pin not driven");
  a_rwm_pins: assert property (
    @(posedge clk) disable iff (!rstn)
    rwm_ff ##1 rwm_ff |-> copi_pin_out == gen_pin_out[5] &&
    cs_pin_out == gen_pin_out[4] && sclk_pin_out == gen_pin_out[3] &&
    copi_pin_oe_n == gen_pin_oe_n[5])
    else $error("reduced mode pins do not follow routing");

  c_parity_err: cover property (@(posedge clk) disable iff (!rstn)
    perr_hit);
  c_rwm_on: cover property (@(posedge clk) disable iff (!rstn)
    $rose(reduced_pin_mode));
  c_chain_on: cover property (@(posedge clk) disable iff (!rstn)
    $rose(chain_mode));
endmodule

//--- hw/spi_frame_link.sv
// spi link side: frame shift, bit count, reply and chain forwarding
`timescale 1ns/1ps
module spi_frame_link (
  // link pins
  input  wire logic   sclk,
  input  wire logic   cs_n,
  input  wire logic   copi,
  input  wire logic   rstn,
  output logic        cipo,
  // control side
  frame_link_if.link  lk
);
  logic        fresh_ff;
  logic        nxt_fresh;
  logic [5:0]  cnt_ff;
  logic [5:0]  nxt_cnt;
  logic [16:0] rx_ff;
  logic [16:0] nxt_rx;
  logic [15:0] dly_ff;
  logic [15:0] nxt_dly;
  logic [5:0]  idx;
  logic        fresh_set_n;

  // fresh marks a frame whose first edge is still to come
  assign fresh_set_n = rstn & ~cs_n;

  always_comb begin
    nxt_fresh = 1'b0;
    nxt_dly   = {dly_ff[14:0], copi};
    if (fresh_ff) begin
      nxt_cnt = io_route_pkg::CNT_ONE;
      nxt_rx  = {16'h0000, copi};
    end else begin
      nxt_cnt = (cnt_ff == io_route_pkg::CNT_MAX) ? cnt_ff
                : cnt_ff + io_route_pkg::CNT_ONE;
      nxt_rx  = {rx_ff[15:0], copi};
    end
  end

  always_ff @(posedge sclk or negedge fresh_set_n) begin
    if (!fresh_set_n) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= nxt_fresh;
    end
  end

  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= io_route_pkg::CNT_ZERO;
      rx_ff  <= 17'h00000;
      dly_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
      rx_ff  <= nxt_rx;
      dly_ff <= nxt_dly;
    end
  end

  // own word first, then upstream bits one word late
  always_comb begin
    idx  = fresh_ff ? io_route_pkg::CNT_ZERO : cnt_ff;
    cipo = 1'b0;
    if (idx < io_route_pkg::LEN_WORD) begin
      cipo = lk.hold_word[4'hF - idx[3:0]];
    end else if (lk.chain_mode) begin
      cipo = dly_ff[15];
    end
  end

  assign lk.rx_word = rx_ff;
  assign lk.bit_cnt = cnt_ff;

  a_chain_forward: assert property (
    @(posedge sclk) disable iff (!rstn || cs_n)
    (lk.chain_mode && !fresh_ff && cnt_ff >= 6'h10 && cnt_ff < 6'h3F
     && $past(cnt_ff, 16) == cnt_ff - 6'h10)
    |-> cipo == $past(copi, 16))
    else $error("chain output is not upstream data one word late");

  c_chain_two: cover property (
    @(posedge sclk) disable iff (!rstn)
    lk.chain_mode && cnt_ff == 6'h20);
endmodule

//--- verif/spi_ctrl_model.sv
// spi controller model: frames msb first, captures reply bits
`timescale 1ns/1ps
module spi_ctrl_model (
  // spi pins
  output logic      sclk,
  output logic      cs_n,
  output logic      copi,
  input  wire logic cipo
);
  logic [31:0] rx;
  event        done;
  initial begin
    {sclk, cs_n, copi} = 3'h2;
    rx = 32'h0;
  end
  // clock stands still between frames, data inverted when idle
  task automatic xfer(input logic [31:0] w, input int n);
    rx = 32'h0;
    #3 cs_n = 1'b0;
    #62;
    for (int i = n - 1; i >= 0; i--) begin
      copi = w[i];
      #16 rx = {rx[30:0], cipo};
      sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    copi = ~copi;
    ->done;
  endtask
endmodule

//--- verif/tb_io_route_top.sv
// bench for the i/o routing and spi mode block
`timescale 1ns/1ps
module tb_io_route_top;
  logic        clk, rstn, pe, d1, d2, bi, fl, rv, pf, cf, ul, rm, cm;
  logic        u, v, w, a, b, z, sck, sda, pw, sclk, cs_n, copi, co;
  logic [2:0]  rs;
  logic [1:0]  rmd;
  logic [7:0]  s8, c8;
  logic [15:0] ang, cw;
  logic        mb, bf;
  logic [25:0] ob, q[$], mq[$];
  logic [31:0] qr[$];
  int          n_mismatch, compares, seed;
  event        look;
  localparam logic [23:0] RT [8] = '{24'h123456, 24'h123EDF, 24'hDEF456,
    24'h123879, 24'hBAC456, 24'h123000, 24'h000456, 24'hDEF000};
  spi_ctrl_model pm (.sclk(sclk), .cs_n(cs_n), .copi(copi), .cipo(co));
  io_route_top dut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .copi(copi), .cipo_out(co), .cipo_oe_n(ob[13]),
    .cipo_pulldown_en(ob[12]), .cs_pullup_en(ob[11]),
    .sclk_pulldown_en(), .copi_pulldown_en(), .cs_pin_out(ob[5]),
    .cs_pin_oe_n(ob[2]), .sclk_pin_out(ob[4]), .sclk_pin_oe_n(ob[1]),
    .copi_pin_out(ob[3]), .copi_pin_oe_n(ob[0]),
    .parity_check_enable(pe), .output_route_select(rs),
    .drive_type_first_group(d1), .drive_type_second_group(d2),
    .spi_input_bias_enable(bi), .idle_output_float(fl), .angle(ang),
    .u_sig(u), .v_sig(v), .w_sig(w), .a_sig(a), .b_sig(b), .z_sig(z),
    .sync_serial_clock_out(sck), .sync_serial_data_out(sda),
    .pwm_sig(pw), .restore_valid(rv), .restore_mode(rmd),
    .restore_crc_stored(s8), .restore_crc_computed(c8),
    .memory_busy_event(mb), .gen_pin_out(ob[25:20]),
    .gen_pin_oe_n(ob[19:14]), .mode_register_unlock(ob[8]),
    .reduced_pin_mode(ob[7]), .chain_mode(ob[6]),
    .parity_error_flag(ob[10]), .restore_crc_error_flag(ob[9]),
    .memory_busy_error_flag(bf), .cmd_valid(), .cmd_word(cw));
  always #4 clk = ~clk;
  // expected pins and status while the link is idle
  function automatic void ex(output logic [25:0] e, m);
    logic [15:0] s;
    logic [3:0]  c;
    logic [5:0]  vv, dd;
    s = {pw, sda, sck, ~z, ~b, ~a, ~w, ~v, ~u, z, b, a, w, v, u, 1'b0};
    for (int i = 0; i < 6; i++) begin
      c = RT[rs][23-4*i -: 4];
      vv[i] = s[c];
      dd[i] = (c == 4'h0) | ((c != 4'hD) & (i < 3 ? d1 : d2) & vv[i]);
    end
    e = {vv, dd, 1'b1, ~fl, bi & ~rm, pf, cf, ul, rm, cm,
         rm ? {vv[4], vv[3], vv[5], dd[4], dd[3], dd[5]} : 6'h07};
    m = {~dd, 14'h3FFF, rm ? ~{dd[4], dd[3], dd[5]} : 3'h0, 3'h7};
  endfunction
  task automatic cmp(input logic [31:0] e, o);
    compares++;
    if (o !== e) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, e, o);
    end
  endtask
  task automatic st();
    logic [25:0] e, m;
    #1;
    ex(e, m);
    q.push_back(e);
    mq.push_back(m);
    ->look;
  endtask
  always @(look) begin
    cmp(32'(q[0] & mq[0]), 32'(ob & mq[0]));
    void'(q.pop_front());
    void'(mq.pop_front());
  end
  always @(pm.done) if (qr.size() > 0) cmp(qr.pop_front(), pm.rx);
  task automatic fr(input logic [31:0] w, input int n, input bit k,
                    input logic [31:0] er);
    if (k) qr.push_back(er);
    pm.xfer(w, n);
    repeat (6) @(posedge clk);
    st();
  endtask
  task automatic rst();
    rstn <= 1'b0;
    {pf, cf, ul, rm, cm} = 5'h00;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000 n_mismatch++;
    test_done();
  end
  initial begin
    seed = 55;
    {clk, rstn, pe, d1, d2, bi, fl, rv, rmd, s8, c8, rs} = 29'h0;
    {u, v, w, a, b, z, sck, sda, pw, mb} = 10'h000;
    ang = 16'($random(seed));
    rst();
    for (int i = 0; i < 16; i++) begin
      {u, v, w, a, b, z, sck, sda, pw, d1, d2, bi, fl} <= 13'($random(seed));
      rs <= i[2:0];
      repeat (3) @(posedge clk);
      st();
    end
    {s8, c8, rmd, rv, mb} <= {8'h5A, 8'h3C, 2'h3, 1'b1, 1'b1};
    @(posedge clk);
    rv <= 1'b0;
    mb <= 1'b0;
    cf = 1'b1;
    repeat (3) @(posedge clk);
    st();
    cmp(32'h1, 32'(bf));
    $display("test routing end");
    {d1, d2, bi, fl, pe} <= 5'h03;
    @(posedge clk);
    fr(32'h0, 16, 0, 0);
    pf = 1'b1;
    fr(32'h1, 17, 0, 0);
    fr(32'h0, 17, 1, {15'h0, ang, 1'b0});
    {pf, cf} = 2'h0;
    fr(32'hC000, 17, 0, 0);
    cmp(32'h0, 32'(bf));
    $display("test parity end");
    pe <= 1'b0;
    fr(32'h2001, 16, 0, 0);
    ul = 1'b1;
    fr(32'h4001, 16, 0, 0);
    fr(32'h2001, 16, 0, 0);
    {ul, rm} = 2'h1;
    fr(32'h4000, 16, 0, 0);
    rs <= 3'h1;
    repeat (3) @(posedge clk);
    st();
    rst();
    st();
    $display("test reduced end");
    fr(32'h8123, 16, 0, 0);
    ul = 1'b1;
    fr(32'h4001, 16, 0, 0);
    fr(32'h2002, 16, 0, 0);
    {ul, cm} = 2'h1;
    fr(32'h4000, 16, 0, 0);
    fr(32'h20010000, 32, 1, {ang, 16'h2001});
    fr(32'h8456, 16, 0, 0);
    cmp(32'h8123, 32'(cw));
    $display("test chain end");
    {c8, rmd, rv} <= {8'h5A, 2'h1, 1'b1};
    @(posedge clk);
    rv <= 1'b0;
    {rm, cm} = 2'h2;
    repeat (3) @(posedge clk);
    st();
    $display("test restore end");
    test_done();
  end
endmodule
